// ==== rtl/asp_serial_port.sv ====
// serial port with fractional baud generator, fifos and infrared codec
// Summary of operation
// [R1] separate transmit and receive enables, set at reset
// [R2] software disables port before reprogramming controls
// [R3] disabling mid-character finishes that character first
// [R4] start, data lsb first, parity, stop
// [R5] five to eight bits, parity modes, stop count
// [R6] two sixteen-entry fifos, receive adds status
// [R7] fifo depth selectable down to one entry
// [R8] fill thresholds one eighth to seven eighths
// [R9] receiver checks overrun, parity, framing, break
// [R10] divisor has 16 integer, 6 fraction bits
// [R11] divisor is clock over sixteen times baud
// [R12] sixteen-times tick times bits and sampling
// [R13] divisor takes effect on line-control write
// [R14] written character starts frame, drains fifo
// [R15] busy until fifo empty and stop sent
// [R16] falling edge starts, eighth tick rejects false
// [R17] data sampled every sixteenth tick, then parity
// [R18] low stop flags framing, entry stored
// [R19] infrared zero is 3/16 high pulse
// [R20] low-power pulse is three low-power ticks
// [R21] low-power tick divides clock by 1..256
// [R22] codec wraps transmit bits and receive input
// [R23] software waits turnaround between ir directions
// [R24] fifos start disabled as single holding registers
// [R25] tick counter reloads, fraction carry adds cycle
//
// The register addresses and the AHB-Lite register port were decided locally.
module asp_serial_port (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // serial line or infrared transceiver
  input wire logic serial_in,
  output logic serial_out
);
  // ==========================================================================
  // state
  typedef struct packed {
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    logic wr_pend;
    logic [11:0] wr_addr;
    logic [15:0] ibrd_stage;
    logic [5:0] fbrd_stage;
    logic [15:0] div_int;
    logic [5:0] div_frac;
    logic [7:0] lcr;
    logic [9:0] ctl;
    logic [5:0] ifls;
    logic [7:0] ilpr;
    logic [3:0] rsr;
    logic [16:0] bcnt;
    logic [5:0] facc;
    logic tick;
    logic [7:0] lpcnt;
    logic lptick;
    asp_pkg::asp_tx_state_type tx_st;
    logic [3:0] tx_tc;
    logic [2:0] tx_idx;
    logic [7:0] tx_shift;
    logic tx_par;
    logic tx_stop2;
    logic tx_line;
    logic [1:0] lp_left;
    logic serial_out;
    asp_pkg::asp_rx_state_type rx_st;
    logic [3:0] rx_tc;
    logic [2:0] rx_idx;
    logic [7:0] rx_shift;
    logic rx_perr;
    logic rx_zero;
    logic rx_ovr;
    logic rx_prev;
    logic [3:0] ir_hold;
  } asp_state_type;
  asp_state_type q;
  asp_state_type next_q;

  logic tx_push;
  logic tx_pop;
  logic rx_push;
  logic rx_pop;
  logic [11:0] rx_entry;
  logic [7:0] tx_head;
  logic [11:0] rx_head;
  logic [4:0] tx_count;
  logic [4:0] rx_count;
  logic fifo_en;
  logic tx_full;
  logic rx_full;
  logic busy;
  logic tx_lvl;
  logic rx_lvl;
  logic rx_dec;
  logic addr_take;
  logic [2:0] last_idx;
  logic [7:0] wmask;

  function automatic logic [4:0] level_of(input logic [2:0] sel);
    unique case (sel)
      3'h0: level_of = 5'h02;
      3'h1: level_of = 5'h04;
      3'h3: level_of = 5'h0c;
      3'h4: level_of = 5'h0e;
      default: level_of = 5'h08;
    endcase
  endfunction

  // ==========================================================================
  // fifos
  asp_fifo #(.WIDTH(asp_pkg::TX_W)) tx_fifo ( // [R6]
    .ref_clk(ref_clk),
    .rst(rst),
    .push(tx_push),
    .push_data(hwdata[7:0]),
    .pop(tx_pop),
    .pop_data(tx_head),
    .count(tx_count)
  );
  asp_fifo #(.WIDTH(asp_pkg::RX_W)) rx_fifo ( // [R6]
    .ref_clk(ref_clk),
    .rst(rst),
    .push(rx_push),
    .push_data(rx_entry),
    .pop(rx_pop),
    .pop_data(rx_head),
    .count(rx_count)
  );

  // ==========================================================================
  // derived status
  assign fifo_en = q.lcr[asp_pkg::LCR_FIFO_EN];
  // fifo disabled: one entry deep, a holding register per direction
  assign tx_full = fifo_en ? (tx_count == asp_pkg::FULL_CNT) : (tx_count != 5'h00); // [R7] [R24]
  assign rx_full = fifo_en ? (rx_count == asp_pkg::FULL_CNT) : (rx_count != 5'h00); // [R7] [R24]
  assign busy = (tx_count != 5'h00) || (q.tx_st != asp_pkg::TX_IDLE); // [R15]
  assign tx_lvl = tx_count <= level_of(q.ifls[2:0]); // [R8]
  assign rx_lvl = rx_count >= level_of(q.ifls[5:3]); // [R8]
  assign last_idx = 3'h4 + {1'b0, q.lcr[asp_pkg::LCR_WLEN +: 2]}; // [R5]
  assign wmask = 8'hff >> (2'h3 - q.lcr[asp_pkg::LCR_WLEN +: 2]); // [R5]
  // half duplex: the decoder is blind while the encoder sends
  assign rx_dec = q.ctl[asp_pkg::CTL_SIR] ?
                  ((serial_in && (q.ir_hold == 4'h0)) || (q.tx_st != asp_pkg::TX_IDLE)) : serial_in; // [R22]
  assign addr_take = hsel && htrans[1] && hready;

  // ==========================================================================
  // next state
  always_comb begin
    logic [31:0] rd;
    logic [6:0] fsum;
    logic [16:0] per;
    logic [7:0] dm;
    logic [7:0] rxd;
    logic expect_par;
    logic newbit;
    logic pulse;
    rd = 32'h0000_0000;
    fsum = {1'b0, q.facc} + {1'b0, q.div_frac};
    per = {1'b0, q.div_int} + {16'h0000, fsum[6]};
    dm = tx_head & wmask;
    rxd = q.rx_shift >> (2'h3 - q.lcr[asp_pkg::LCR_WLEN +: 2]);
    expect_par = q.lcr[asp_pkg::LCR_STICK] ? !q.lcr[asp_pkg::LCR_EVEN] :
                 (q.lcr[asp_pkg::LCR_EVEN] ? ^rxd : ~^rxd);
    newbit = 1'b0;
    pulse = 1'b0;
    next_q = q;
    tx_push = 1'b0;
    tx_pop = 1'b0;
    rx_push = 1'b0;
    rx_pop = 1'b0;
    rx_entry = {q.rx_ovr, q.rx_zero && !rx_dec, q.rx_perr, !rx_dec, rxd};

    // bus: zero wait states, always okay
    next_q.hreadyout = 1'b1;
    next_q.hresp = 1'b0;
    unique case (haddr[11:0])
      asp_pkg::OFF_DATA: rd = (rx_count != 5'h00) ? {20'h00000, rx_head} : 32'h0000_0000;
      asp_pkg::OFF_RSR: rd = {28'h0000000, q.rsr};
      asp_pkg::OFF_FLAG: rd = {22'h000000, tx_lvl, rx_lvl, tx_count == 5'h00, rx_full, tx_full,
                               rx_count == 5'h00, busy, 3'h0};
      asp_pkg::OFF_ILPR: rd = {24'h000000, q.ilpr};
      asp_pkg::OFF_IBRD: rd = {16'h0000, q.ibrd_stage};
      asp_pkg::OFF_FBRD: rd = {26'h0000000, q.fbrd_stage};
      asp_pkg::OFF_LCR: rd = {24'h000000, q.lcr};
      asp_pkg::OFF_CTL: rd = {22'h000000, q.ctl};
      asp_pkg::OFF_IFLS: rd = {26'h0000000, q.ifls};
      default: rd = 32'h0000_0000;
    endcase
    next_q.wr_pend = addr_take && hwrite;
    if (addr_take) begin
      next_q.wr_addr = haddr[11:0];
    end
    if (q.wr_pend) begin
      unique case (q.wr_addr)
        asp_pkg::OFF_DATA: tx_push = !tx_full; // [R14]
        asp_pkg::OFF_RSR: next_q.rsr = 4'h0;
        asp_pkg::OFF_ILPR: next_q.ilpr = hwdata[7:0];
        asp_pkg::OFF_IBRD: next_q.ibrd_stage = hwdata[15:0]; // [R10]
        asp_pkg::OFF_FBRD: next_q.fbrd_stage = hwdata[5:0]; // [R10]
        asp_pkg::OFF_LCR: begin
          next_q.lcr = hwdata[7:0];
          next_q.div_int = q.ibrd_stage; // [R13]
          next_q.div_frac = q.fbrd_stage; // [R13]
        end
        asp_pkg::OFF_CTL: next_q.ctl = hwdata[9:0] & asp_pkg::CTL_MASK;
        asp_pkg::OFF_IFLS: next_q.ifls = hwdata[5:0];
        default: ;
      endcase
    end
    if (addr_take && !hwrite) begin
      next_q.hrdata = rd;
      if ((haddr[11:0] == asp_pkg::OFF_DATA) && (rx_count != 5'h00)) begin
        rx_pop = 1'b1;
        next_q.rsr[2:0] = rx_head[10:8]; // [R9]
      end
    end

    // ========================================================================
    // baud tick: fraction carry stretches one period by a cycle
    next_q.tick = (q.bcnt == 17'h00000); // [R25]
    if (q.bcnt == 17'h00000) begin
      next_q.facc = fsum[5:0]; // [R11] [R25]
      next_q.bcnt = (per == 17'h00000) ? 17'h00000 : per - 17'h00001; // [R25]
    end else begin
      next_q.bcnt = q.bcnt - 17'h00001;
    end
    // low-power tick, a setting of zero divides by 256
    next_q.lptick = (q.lpcnt == 8'h00); // [R21]
    next_q.lpcnt = (q.lpcnt == 8'h00) ? q.ilpr - 8'h01 : q.lpcnt - 8'h01; // [R21]

    // ========================================================================
    // transmitter
    if (q.tx_st == asp_pkg::TX_IDLE) begin
      next_q.tx_line = 1'b1;
      // new frames only while enabled, so a running one always completes
      if ((tx_count != 5'h00) && q.ctl[asp_pkg::CTL_EN] && q.ctl[asp_pkg::CTL_TX_EN]) begin // [R1] [R3] [R14]
        tx_pop = 1'b1;
        next_q.tx_shift = dm;
        next_q.tx_par = q.lcr[asp_pkg::LCR_STICK] ? !q.lcr[asp_pkg::LCR_EVEN] :
                        (q.lcr[asp_pkg::LCR_EVEN] ? ^dm : ~^dm); // [R5]
        next_q.tx_st = asp_pkg::TX_START; // [R4]
        next_q.tx_tc = 4'h0;
        next_q.tx_idx = 3'h0;
        next_q.tx_stop2 = 1'b0;
        next_q.tx_line = 1'b0;
        newbit = 1'b1;
      end
    end else if (q.tick) begin
      next_q.tx_tc = q.tx_tc + 4'h1; // [R12]
      if (q.tx_tc == asp_pkg::BIT_LAST) begin
        newbit = 1'b1;
        unique case (q.tx_st)
          asp_pkg::TX_START: begin
            next_q.tx_st = asp_pkg::TX_DATA;
            next_q.tx_line = q.tx_shift[0]; // [R4]
          end
          asp_pkg::TX_DATA: begin
            next_q.tx_shift = q.tx_shift >> 1;
            next_q.tx_idx = q.tx_idx + 3'h1;
            next_q.tx_line = q.tx_shift[1]; // [R4]
            if (q.tx_idx == last_idx) begin
              next_q.tx_st = q.lcr[asp_pkg::LCR_PEN] ? asp_pkg::TX_PAR : asp_pkg::TX_STOP; // [R5]
              next_q.tx_line = q.lcr[asp_pkg::LCR_PEN] ? q.tx_par : 1'b1;
            end
          end
          asp_pkg::TX_PAR: begin
            next_q.tx_st = asp_pkg::TX_STOP;
            next_q.tx_line = 1'b1;
          end
          asp_pkg::TX_STOP: begin
            if (q.lcr[asp_pkg::LCR_STOP2] && !q.tx_stop2) begin // [R5]
              next_q.tx_stop2 = 1'b1;
            end else begin
              next_q.tx_st = asp_pkg::TX_IDLE; // [R15]
            end
          end
          default: next_q.tx_st = asp_pkg::TX_IDLE;
        endcase
      end
    end

    // ========================================================================
    // infrared encoder and line output
    if (newbit && !next_q.tx_line && (next_q.tx_st != asp_pkg::TX_IDLE)) begin
      next_q.lp_left = asp_pkg::LP_PULSE; // [R20]
    end else if (q.lptick && (q.lp_left != 2'h0)) begin
      next_q.lp_left = q.lp_left - 2'h1; // [R20]
    end
    if (q.ctl[asp_pkg::CTL_SIR_LP]) begin
      pulse = q.lp_left != 2'h0; // [R20]
    end else begin
      pulse = (q.tx_st != asp_pkg::TX_IDLE) && !q.tx_line && (q.tx_tc < asp_pkg::IR_PULSE); // [R19]
    end
    next_q.serial_out = q.ctl[asp_pkg::CTL_SIR] ? pulse : (q.tx_line && !q.lcr[asp_pkg::LCR_BRK]); // [R22]

    // ========================================================================
    // infrared decoder stretches a short low pulse over the bit centre
    if (!serial_in) begin
      next_q.ir_hold = asp_pkg::IR_HOLD; // [R22]
    end else if (q.tick && (q.ir_hold != 4'h0)) begin
      next_q.ir_hold = q.ir_hold - 4'h1;
    end
    next_q.rx_prev = rx_dec;

    // ========================================================================
    // receiver
    if (q.rx_st == asp_pkg::RX_IDLE) begin
      if (q.ctl[asp_pkg::CTL_EN] && q.ctl[asp_pkg::CTL_RX_EN] && q.rx_prev && !rx_dec) begin // [R1] [R3] [R16]
        next_q.rx_st = asp_pkg::RX_START;
        next_q.rx_tc = 4'h0;
      end
    end else if (q.tick) begin
      next_q.rx_tc = q.rx_tc + 4'h1;
      unique case (q.rx_st)
        asp_pkg::RX_START: begin
          if (q.rx_tc == asp_pkg::START_SAMPLE) begin
            next_q.rx_st = rx_dec ? asp_pkg::RX_IDLE : asp_pkg::RX_DATA; // [R16]
            next_q.rx_tc = 4'h0;
            next_q.rx_idx = 3'h0;
            next_q.rx_perr = 1'b0;
            next_q.rx_zero = 1'b1;
          end
        end
        asp_pkg::RX_DATA: begin
          if (q.rx_tc == asp_pkg::BIT_LAST) begin
            next_q.rx_shift = {rx_dec, q.rx_shift[7:1]}; // [R17]
            next_q.rx_zero = q.rx_zero && !rx_dec;
            next_q.rx_idx = q.rx_idx + 3'h1;
            if (q.rx_idx == last_idx) begin
              next_q.rx_st = q.lcr[asp_pkg::LCR_PEN] ? asp_pkg::RX_PAR : asp_pkg::RX_STOP; // [R17]
            end
          end
        end
        asp_pkg::RX_PAR: begin
          if (q.rx_tc == asp_pkg::BIT_LAST) begin
            next_q.rx_perr = rx_dec != expect_par; // [R9] [R17]
            next_q.rx_zero = q.rx_zero && !rx_dec;
            next_q.rx_st = asp_pkg::RX_STOP;
          end
        end
        asp_pkg::RX_STOP: begin
          if (q.rx_tc == asp_pkg::BIT_LAST) begin
            next_q.rx_st = asp_pkg::RX_IDLE;
            if (rx_full) begin
              next_q.rsr[asp_pkg::RSR_OVR] = 1'b1; // [R9]
              next_q.rx_ovr = 1'b1;
            end else begin
              rx_push = 1'b1; // [R18]
              next_q.rx_ovr = 1'b0;
            end
          end
        end
        default: next_q.rx_st = asp_pkg::RX_IDLE;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      q <= '0;
      q.hreadyout <= 1'b1;
      q.ctl <= asp_pkg::CTL_RESET; // [R1]
      q.ifls <= asp_pkg::IFLS_RESET;
      q.tx_st <= asp_pkg::TX_IDLE;
      q.rx_st <= asp_pkg::RX_IDLE;
      q.tx_line <= 1'b1;
      q.rx_prev <= 1'b1;
      q.serial_out <= 1'b1;
    end else begin
      q <= next_q;
    end
  end

  assign hrdata = q.hrdata;
  assign hreadyout = q.hreadyout;
  assign hresp = q.hresp;
  assign serial_out = q.serial_out;

  // ==========================================================================
  // checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  sequence tick_gap2;
    !q.tick ##1 q.tick;
  endsequence

  a_reset_enables: assert property ($fell(rst) |-> q.ctl[asp_pkg::CTL_TX_EN] && q.ctl[asp_pkg::CTL_RX_EN]) // [R1]
    else $error("enables not set after reset");
  a_start_low: assert property ((q.tx_st == asp_pkg::TX_START && !q.ctl[asp_pkg::CTL_SIR] && // [R4]
      !q.lcr[asp_pkg::LCR_BRK]) |=> !serial_out)
    else $error("start bit not low");
  a_tx_lsb_first: assert property ((q.tx_st == asp_pkg::TX_START && q.tick && q.tx_tc == 4'hf) // [R4]
      |=> q.tx_st == asp_pkg::TX_DATA && q.tx_line == $past(q.tx_shift[0]))
    else $error("first data bit not lsb");
  a_false_start: assert property ((q.rx_st == asp_pkg::RX_START && q.tick && q.rx_tc == 4'h7 && rx_dec) // [R16]
      |=> q.rx_st == asp_pkg::RX_IDLE)
    else $error("false start not rejected");
  a_start_accept: assert property ((q.rx_st == asp_pkg::RX_START && q.tick && q.rx_tc == 4'h7 && !rx_dec) // [R12]
      |=> q.rx_st == asp_pkg::RX_DATA && q.rx_tc == 4'h0)
    else $error("valid start not accepted");
  a_busy_on_write: assert property ((q.wr_pend && q.wr_addr == asp_pkg::OFF_DATA && !tx_full) |=> busy) // [R15]
    else $error("busy not raised by write");
  a_divisor_held: assert property ((q.wr_pend && q.wr_addr != asp_pkg::OFF_LCR) // [R13]
      |=> $stable(q.div_int) && $stable(q.div_frac))
    else $error("divisor changed without line control write");
  a_divisor_load: assert property ((q.wr_pend && q.wr_addr == asp_pkg::OFF_LCR) // [R13]
      |=> q.div_int == $past(q.ibrd_stage) && q.div_frac == $past(q.fbrd_stage))
    else $error("divisor not loaded by line control write");
  a_framing_flag: assert property ((q.rx_st == asp_pkg::RX_STOP && q.tick && q.rx_tc == 4'hf && // [R18]
      !rx_dec && !rx_full) |-> rx_push && rx_entry[asp_pkg::ENT_FE])
    else $error("framing error not stored");
  a_overrun_flag: assert property ((q.rx_st == asp_pkg::RX_STOP && q.tick && q.rx_tc == 4'hf && rx_full) // [R9]
      |=> q.rsr[asp_pkg::RSR_OVR] && !rx_push)
    else $error("overrun not flagged");
  a_tick_period: assert property ((q.tick && q.div_int == 16'h0002 && q.div_frac == 6'h00 && // [R25]
      $stable(q.div_int)) |=> tick_gap2)
    else $error("tick period wrong");
endmodule // asp_serial_port

// ==== rtl/asp_pkg.sv ====
// constants, field positions and state encodings of the serial port
package asp_pkg;
  // ==========================================================================
  // fifo geometry
  localparam int DEPTH = 16;
  localparam int PTR_W = 4;
  localparam int CNT_W = 5;
  localparam logic [4:0] FULL_CNT = 5'h10;
  localparam int TX_W = 8;
  localparam int RX_W = 12;
  // ==========================================================================
  // register offsets (byte addresses)
  localparam logic [11:0] OFF_DATA = 12'h000;
  localparam logic [11:0] OFF_RSR = 12'h004;
  localparam logic [11:0] OFF_FLAG = 12'h018;
  localparam logic [11:0] OFF_ILPR = 12'h020;
  localparam logic [11:0] OFF_IBRD = 12'h024;
  localparam logic [11:0] OFF_FBRD = 12'h028;
  localparam logic [11:0] OFF_LCR = 12'h02c;
  localparam logic [11:0] OFF_CTL = 12'h030;
  localparam logic [11:0] OFF_IFLS = 12'h034;
  // ==========================================================================
  // line control fields
  localparam int LCR_BRK = 0;
  localparam int LCR_PEN = 1;
  localparam int LCR_EVEN = 2;
  localparam int LCR_STOP2 = 3;
  localparam int LCR_FIFO_EN = 4;
  localparam int LCR_WLEN = 5;
  localparam int LCR_STICK = 7;
  // ==========================================================================
  // port control fields and reset values
  localparam int CTL_EN = 0;
  localparam int CTL_SIR = 1;
  localparam int CTL_SIR_LP = 2;
  localparam int CTL_TX_EN = 8;
  localparam int CTL_RX_EN = 9;
  localparam logic [9:0] CTL_MASK = 10'h307;
  localparam logic [9:0] CTL_RESET = 10'h300;
  localparam logic [5:0] IFLS_RESET = 6'h12;
  // ==========================================================================
  // receive entry and status bits
  localparam int ENT_FE = 8;
  localparam int RSR_OVR = 3;
  // ==========================================================================
  // timing counts in oversampling ticks, LP_PULSE in low-power ticks
  localparam logic [3:0] START_SAMPLE = 4'h7;
  localparam logic [3:0] BIT_LAST = 4'hf;
  localparam logic [3:0] IR_PULSE = 4'h3;
  localparam logic [3:0] IR_HOLD = 4'hc;
  localparam logic [1:0] LP_PULSE = 2'h3;
  // ==========================================================================
  // state encodings
  typedef enum logic [4:0] {
    TX_IDLE = 5'h01,
    TX_START = 5'h02,
    TX_DATA = 5'h04,
    TX_PAR = 5'h08,
    TX_STOP = 5'h10
  } asp_tx_state_type;
  typedef enum logic [4:0] {
    RX_IDLE = 5'h01,
    RX_START = 5'h02,
    RX_DATA = 5'h04,
    RX_PAR = 5'h08,
    RX_STOP = 5'h10
  } asp_rx_state_type;
endpackage

// ==== rtl/asp_fifo.sv ====
// sixteen-entry flip-flop fifo used for both directions
module asp_fifo #(
  parameter int WIDTH = 8
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // filling side
  input wire logic push,
  input wire logic [WIDTH-1:0] push_data,
  // draining side
  input wire logic pop,
  output logic [WIDTH-1:0] pop_data,
  // fill level
  output logic [asp_pkg::CNT_W-1:0] count
);
  // ==========================================================================
  // state
  typedef struct packed {
    logic [asp_pkg::DEPTH-1:0][WIDTH-1:0] mem;
    logic [asp_pkg::PTR_W-1:0] wr;
    logic [asp_pkg::PTR_W-1:0] rd;
    logic [asp_pkg::CNT_W-1:0] cnt;
  } asp_fifo_state_type;
  asp_fifo_state_type q;
  asp_fifo_state_type next_q;
  logic do_push;
  logic do_pop;

  // pushes into a full fifo and pops from an empty one are dropped
  assign do_push = push && (q.cnt != asp_pkg::FULL_CNT);
  assign do_pop = pop && (q.cnt != 5'h00);
  assign pop_data = q.mem[q.rd];
  assign count = q.cnt;

  always_comb begin
    next_q = q;
    if (do_push) begin
      next_q.mem[q.wr] = push_data;
      next_q.wr = q.wr + 4'h1;
    end
    if (do_pop) begin
      next_q.rd = q.rd + 4'h1;
    end
    if (do_push && !do_pop) begin
      next_q.cnt = q.cnt + 5'h01;
    end else if (do_pop && !do_push) begin
      next_q.cnt = q.cnt - 5'h01;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end
endmodule // asp_fifo

// ==== tb/asp_remote.sv ====
// remote serial device model facing the port's serial pins
module asp_remote #(
  parameter int BIT = 32
) (
  // clock
  input wire logic ref_clk,
  // line from the port
  input wire logic serial_out,
  // line into the port
  output logic serial_in
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] got_byte;
  logic got_stop;
  logic [7:0] sh;
  int got_cnt;
  initial begin
    serial_in = 1'b1;
    got_cnt = 0;
  end
  // ==========================================================================
  // decoder: mid-bit sampling, so a late or short bit shows as a wrong value
  initial forever begin
    @(negedge serial_out);
    repeat (BIT / 2) @(posedge ref_clk);
    if (serial_out === 1'b0) begin
      for (int i = 0; i < 8; i++) begin
        repeat (BIT) @(posedge ref_clk);
        sh[i] = serial_out;
      end
      repeat (BIT) @(posedge ref_clk);
      got_stop = serial_out;
      got_byte = sh;
      got_cnt++;
    end
  end
  // ==========================================================================
  // encoder: start, data lsb first, stop, then one idle bit
  task automatic send(input logic [7:0] b, input logic stop);
    logic [9:0] f;
    f = {stop, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      serial_in <= f[i];
      repeat (BIT) @(posedge ref_clk);
    end
    serial_in <= 1'b1;
    repeat (BIT) @(posedge ref_clk);
  endtask
  task automatic glitch(input int n);
    serial_in <= 1'b0;
    repeat (n) @(posedge ref_clk);
    serial_in <= 1'b1;
  endtask
endmodule  // asp_remote

// ==== tb/asp_serial_port_test.sv ====
// self-checking bench: registers, transmit, receive, false start, overrun and infrared
module asp_serial_port_test;
  timeunit 1ns;
  timeprecision 1ns;
  // divisor 2 gives 16 ticks of 2 clocks per bit
  localparam int BIT = 32;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic serial_in;
  logic serial_out;
  logic [31:0] rd;
  int err_total = 0;
  int checks = 0;
  always #50 ref_clk = ~ref_clk;
  asp_serial_port asp_serial_port_i (.ref_clk(ref_clk), .rst(rst), .hsel(1'b1), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .serial_in(serial_in), .serial_out(serial_out));
  asp_remote #(.BIT(BIT)) asp_remote_i (.ref_clk(ref_clk), .serial_out(serial_out), .serial_in(serial_in));
  // ==========================================================================
  // shared tasks
  task automatic wrap_up();
    $display("checks %0d, mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask
  task automatic wait_ready();
    int n;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (hreadyout !== 1'b1 && n < 100);
    if (n >= 100) begin
      err_total++;
      wrap_up();
    end
  endtask
  // address phase until ready, then data phase until ready
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    haddr <= {20'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    wait_ready();
    htrans <= 2'h0;
    hwdata <= d;
    wait_ready();
    rd = hrdata;
    chk("response", 32'h0, {31'h0, hresp});
  endtask
  task automatic wait_rx(input int c);
    int n;
    n = 0;
    while (asp_remote_i.got_cnt == c && n < 20 * BIT) begin
      @(posedge ref_clk);
      n++;
    end
    if (n >= 20 * BIT) begin
      err_total++;
      wrap_up();
    end
  endtask
  // ==========================================================================
  // scenarios
  task automatic t_reset();
    bus(1'b0, asp_pkg::OFF_CTL, 32'h0);
    chk("control", 32'h300, rd);
    bus(1'b0, asp_pkg::OFF_FLAG, 32'h0);
    chk("flags", 32'h290, rd);
    bus(1'b0, 12'h100, 32'h0);
    chk("unmapped", 32'h0, rd);
    $display("reset test done");
  endtask
  // divisor 4 left unlatched must not change the bit time
  task automatic t_tx();
    int c;
    c = asp_remote_i.got_cnt;
    bus(1'b1, asp_pkg::OFF_CTL, 32'h300);
    bus(1'b1, asp_pkg::OFF_IBRD, 32'h2);
    bus(1'b1, asp_pkg::OFF_FBRD, 32'h0);
    bus(1'b1, asp_pkg::OFF_LCR, 32'h60);
    bus(1'b1, asp_pkg::OFF_IBRD, 32'h4);
    bus(1'b1, asp_pkg::OFF_CTL, 32'h301);
    bus(1'b1, asp_pkg::OFF_DATA, 32'ha5);
    bus(1'b0, asp_pkg::OFF_FLAG, 32'h0);
    chk("busy", 32'h1, {31'h0, rd[3]});
    bus(1'b1, asp_pkg::OFF_CTL, 32'h300);
    wait_rx(c);
    chk("sent byte", 32'ha5, {24'h0, asp_remote_i.got_byte});
    chk("stop bit", 32'h1, {31'h0, asp_remote_i.got_stop});
    repeat (2 * BIT) @(posedge ref_clk);
    bus(1'b0, asp_pkg::OFF_FLAG, 32'h0);
    chk("busy end", 32'h0, {31'h0, rd[3]});
    $display("transmit test done");
  endtask
  task automatic t_rx();
    logic [7:0] dat [3] = '{8'h3c, 8'h81, 8'h00};
    logic stp [3] = '{1'b1, 1'b0, 1'b0};
    logic [31:0] exp [3] = '{32'h03c, 32'h181, 32'h500};
    bus(1'b1, asp_pkg::OFF_CTL, 32'h301);
    asp_remote_i.glitch(6);
    repeat (12 * BIT) @(posedge ref_clk);
    bus(1'b0, asp_pkg::OFF_FLAG, 32'h0);
    chk("rx empty", 32'h1, {31'h0, rd[4]});
    bus(1'b0, asp_pkg::OFF_DATA, 32'h0);
    chk("empty read", 32'h0, rd);
    for (int i = 0; i < 3; i++) begin
      asp_remote_i.send(dat[i], stp[i]);
      bus(1'b0, asp_pkg::OFF_DATA, 32'h0);
      chk("received entry", exp[i], rd);
    end
    $display("receive test done");
  endtask
  // fifo off: a second character into a full holding register is lost
  task automatic t_overrun();
    asp_remote_i.send(8'h11, 1'b1);
    asp_remote_i.send(8'h22, 1'b1);
    bus(1'b0, asp_pkg::OFF_DATA, 32'h0);
    chk("kept entry", 32'h011, rd);
    bus(1'b0, asp_pkg::OFF_RSR, 32'h0);
    chk("overrun status", 32'h8, rd);
    bus(1'b1, asp_pkg::OFF_RSR, 32'h0);
    asp_remote_i.send(8'h33, 1'b1);
    bus(1'b0, asp_pkg::OFF_DATA, 32'h0);
    chk("entry after overrun", 32'h833, rd);
    $display("overrun test done");
  endtask
  // 0x5a has four zero bits plus the start bit, each a pulse of 3 ticks
  task automatic t_ir();
    int pulses;
    int hi;
    logic last;
    pulses = 0;
    hi = 0;
    last = 1'b0;
    bus(1'b1, asp_pkg::OFF_CTL, 32'h302);
    bus(1'b1, asp_pkg::OFF_CTL, 32'h303);
    bus(1'b1, asp_pkg::OFF_DATA, 32'h5a);
    repeat (11 * BIT) begin
      @(posedge ref_clk);
      if (serial_out && !last) begin
        pulses++;
      end
      if (serial_out) begin
        hi++;
      end
      last = serial_out;
    end
    chk("ir pulses", 32'h5, pulses);
    // start pulse may lose one clock to the tick phase
    chk("ir high time", 32'h1, {31'h0, hi >= 29 && hi <= 30});
    // transmit only: no ir reception follows, so no turnaround wait is due
    bus(1'b1, asp_pkg::OFF_CTL, 32'h300);
    $display("infrared test done");
  endtask
  initial begin
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    t_reset();
    t_tx();
    t_rx();
    t_overrun();
    t_ir();
    wrap_up();
  end
endmodule  // asp_serial_port_test
